/* File: hw/upsw_pkg.sv */
// package: register map, field positions, reset values and filter timing for the status bank
package upsw_pkg;

    localparam int CLK_MHZ = 200;

    // byte offsets on the register bus
    localparam logic [7:0] OFS_UTMI_STATUS = 8'h30;
    localparam logic [7:0] OFS_PHY_STATUS  = 8'h34;
    localparam logic [7:0] OFS_FILTER_CTRL = 8'h38;
    localparam logic [7:0] OFS_WAKEUP_CTRL = 8'h40;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h44;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h48;

    // write-mask half word of control registers
    localparam int WMASK_LSB = 16;
    localparam int DATA_BITS = 16;

    // filter control field positions
    localparam int FLT_LS_LSB = 2;
    localparam int FLT_ID_LSB = 0;

    // wakeup / interrupt field positions
    localparam int WK_LINE_STATE = 0;
    localparam int WK_RX_DETECT  = 1;
    localparam int WK_BVALID_LSB = 2;
    localparam int WK_ID_LSB     = 4;
    localparam int WK_BITS       = 6;
    localparam int WK_RXDET_EN   = 4;

    // reset values
    localparam logic [15:0]       RST_CTRL16 = 16'h0000;
    localparam logic [1:0]        RST_SEL    = 2'h0;
    localparam logic [WK_BITS-1:0] RST_WK    = 6'h00;

    // debounce intervals in microseconds
    localparam int LS_T0_US = 100;
    localparam int LS_T1_US = 500;
    localparam int LS_T2_US = 1000;
    localparam int LS_T3_US = 10000;
    localparam int ID_T0_US = 5000;
    localparam int ID_T1_US = 15000;
    localparam int ID_T2_US = 35000;

    // interval counts in clock cycles
    localparam int LS_CYC0 = LS_T0_US * CLK_MHZ;
    localparam int LS_CYC1 = LS_T1_US * CLK_MHZ;
    localparam int LS_CYC2 = LS_T2_US * CLK_MHZ;
    localparam int LS_CYC3 = LS_T3_US * CLK_MHZ;
    localparam int ID_CYC0 = ID_T0_US * CLK_MHZ;
    localparam int ID_CYC1 = ID_T1_US * CLK_MHZ;
    localparam int ID_CYC2 = ID_T2_US * CLK_MHZ;

    localparam int CNT_W = 24;

    // number of synchronised status input bits
    localparam int SYNC_W = 36;

endpackage : upsw_pkg

/* File: hw/upsw_regs.sv */
// module: phy status / wakeup register bank with ahb-lite slave, debounce filters and interrupt
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
module upsw_regs
    import upsw_pkg::*;
#(
    parameter int LS_CNT0 = LS_CYC0,
    parameter int LS_CNT1 = LS_CYC1,
    parameter int LS_CNT2 = LS_CYC2,
    parameter int LS_CNT3 = LS_CYC3,
    parameter int ID_CNT0 = ID_CYC0,
    parameter int ID_CNT1 = ID_CYC1,
    parameter int ID_CNT2 = ID_CYC2
) (
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // pipe3 / phy sideband
    input  wire logic        transmit_pll_locked,
    input  wire logic        pipe_reset_level,
    input  wire logic [7:0]  phy_observe_bus,
    input  wire logic        elastic_buffer_mode_mirror,
    input  wire logic [1:0]  pipe_power_down,
    input  wire logic        rx_eq_training,
    input  wire logic        rx_polarity,
    input  wire logic        rx_termination,
    input  wire logic        tx_detect_rx_loopback,
    input  wire logic        tx_compliance,
    input  wire logic        tx_ones_zeros,
    input  wire logic        phy_status_done,
    input  wire logic        rx_elec_idle,
    input  wire logic [2:0]  rx_status,
    input  wire logic        rx_valid,
    input  wire logic        power_present,
    input  wire logic        receiver_detected,
    // utmi sideband
    input  wire logic        b_session_valid,
    input  wire logic        host_disconnect,
    input  wire logic        id_digital,
    input  wire logic [1:0]  line_state,
    input  wire logic        session_end,
    input  wire logic        vbus_valid,
    input  wire logic        vm_in,
    input  wire logic        vp_in,
    // block outputs
    output logic             receiver_detect_enable,
    output logic [1:0]       line_state_filtered,
    output logic             id_filtered,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [15:0] masked_write(input logic [15:0] old_val,
                                                 input logic [31:0] wdata);
        logic [15:0] wmask;
        wmask = wdata[WMASK_LSB +: DATA_BITS];
        masked_write = (old_val & ~wmask) | (wdata[DATA_BITS-1:0] & wmask);
    endfunction : masked_write

    ////////////////////////////////////////////////////////////////////////////////
    // input synchroniser

    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;

    assign sync_raw = {receiver_detected, b_session_valid, host_disconnect, id_digital,
                       line_state, session_end, vbus_valid, vm_in, vp_in,
                       transmit_pll_locked, pipe_reset_level, phy_observe_bus,
                       elastic_buffer_mode_mirror, pipe_power_down, rx_eq_training,
                       rx_polarity, rx_termination, tx_detect_rx_loopback, tx_compliance,
                       tx_ones_zeros, phy_status_done, rx_elec_idle, rx_status, rx_valid,
                       power_present};

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync_raw;
            sync2_q <= sync1_q;
        end
    end

    logic [25:0] phy_s;
    logic        rxdet_s;
    logic        bvalid_s;
    logic        hostdisc_s;
    logic        id_s;
    logic [1:0]  ls_s;
    logic [3:0]  utmi_lo_s;

    assign phy_s      = sync2_q[25:0];
    assign utmi_lo_s  = sync2_q[29:26];
    assign ls_s       = sync2_q[31:30];
    assign id_s       = sync2_q[32];
    assign hostdisc_s = sync2_q[33];
    assign bvalid_s   = sync2_q[34];
    assign rxdet_s    = sync2_q[35];

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: writes zero wait, reads one wait state

    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        rd_pend_q;
    logic [7:0]  rd_addr_q;
    logic        accept;

    assign accept = hsel && hready && htrans[1];

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rd_pend_q <= 1'b0;
            rd_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= accept && hwrite;
            rd_pend_q <= accept && !hwrite;
            if (accept) begin
                wr_addr_q <= haddr[7:0];
                rd_addr_q <= haddr[7:0];
            end
        end
    end

    // read wait state lets a write in the previous data phase land first
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= !(accept && !hwrite);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    logic wr_filter;
    logic wr_wakeup;
    logic wr_irq_stat;
    logic wr_irq_mask;

    assign wr_filter   = wr_pend_q && (wr_addr_q == OFS_FILTER_CTRL);
    assign wr_wakeup   = wr_pend_q && (wr_addr_q == OFS_WAKEUP_CTRL);
    assign wr_irq_stat = wr_pend_q && (wr_addr_q == OFS_IRQ_STATUS);
    assign wr_irq_mask = wr_pend_q && (wr_addr_q == OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // control registers with write mask

    logic [15:0] filter_q;
    logic [15:0] wake_ctl_q;
    logic [15:0] irq_mask_q;
    logic [15:0] filter_d;
    logic [15:0] wake_ctl_d;
    logic [15:0] irq_mask_d;

    assign filter_d   = masked_write(filter_q, hwdata);
    assign wake_ctl_d = masked_write(wake_ctl_q, hwdata);
    assign irq_mask_d = masked_write(irq_mask_q, hwdata);

    always_ff @(posedge clk) begin
        if (rst) begin
            filter_q <= RST_CTRL16;
        end else if (wr_filter) begin
            filter_q <= {12'h000, filter_d[3:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wake_ctl_q <= RST_CTRL16;
        end else if (wr_wakeup) begin
            wake_ctl_q <= {10'h000, wake_ctl_d[WK_BITS-1:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_q <= RST_CTRL16;
        end else if (wr_irq_mask) begin
            irq_mask_q <= {10'h000, irq_mask_d[WK_BITS-1:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            receiver_detect_enable <= 1'b0;
        end else begin
            receiver_detect_enable <= wake_ctl_q[WK_RXDET_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // debounce filters

    logic [1:0]       ls_sel;
    logic [1:0]       id_sel;
    logic [CNT_W-1:0] ls_limit;
    logic [CNT_W-1:0] id_limit;

    assign ls_sel = filter_q[FLT_LS_LSB +: 2];
    assign id_sel = filter_q[FLT_ID_LSB +: 2];

    always_comb begin
        case (ls_sel)
            2'h0:    ls_limit = CNT_W'(LS_CNT0);
            2'h1:    ls_limit = CNT_W'(LS_CNT1);
            2'h2:    ls_limit = CNT_W'(LS_CNT2);
            default: ls_limit = CNT_W'(LS_CNT3);
        endcase
    end

    // code 11 has no interval of its own; it reuses the longest
    always_comb begin
        case (id_sel)
            2'h0:    id_limit = CNT_W'(ID_CNT0);
            2'h1:    id_limit = CNT_W'(ID_CNT1);
            default: id_limit = CNT_W'(ID_CNT2);
        endcase
    end

    logic [1:0]       ls_cand_q;
    logic [CNT_W-1:0] ls_cnt_q;
    logic             id_cand_q;
    logic [CNT_W-1:0] id_cnt_q;

    // candidate restarts the count whenever the raw level moves again
    always_ff @(posedge clk) begin
        if (rst) begin
            ls_cand_q           <= 2'h0;
            ls_cnt_q            <= '0;
            line_state_filtered <= 2'h0;
        end else if (ls_s == line_state_filtered) begin
            ls_cand_q <= ls_s;
            ls_cnt_q  <= '0;
        end else if (ls_s != ls_cand_q) begin
            ls_cand_q <= ls_s;
            ls_cnt_q  <= CNT_W'(1);
        end else if (ls_cnt_q >= ls_limit) begin
            line_state_filtered <= ls_cand_q;
            ls_cnt_q            <= '0;
        end else begin
            ls_cnt_q <= ls_cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            id_cand_q   <= 1'b0;
            id_cnt_q    <= '0;
            id_filtered <= 1'b0;
        end else if (id_s == id_filtered) begin
            id_cand_q <= id_s;
            id_cnt_q  <= '0;
        end else if (id_s != id_cand_q) begin
            id_cand_q <= id_s;
            id_cnt_q  <= CNT_W'(1);
        end else if (id_cnt_q >= id_limit) begin
            id_filtered <= id_cand_q;
            id_cnt_q    <= '0;
        end else begin
            id_cnt_q <= id_cnt_q + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wakeup events and interrupt

    logic [1:0]         ls_prev_q;
    logic               id_prev_q;
    logic               bvalid_prev_q;
    logic               rxdet_prev_q;
    logic [WK_BITS-1:0] events;
    logic [WK_BITS-1:0] irq_stat_q;
    logic [WK_BITS-1:0] irq_clr;

    always_ff @(posedge clk) begin
        if (rst) begin
            ls_prev_q     <= 2'h0;
            id_prev_q     <= 1'b0;
            bvalid_prev_q <= 1'b0;
            rxdet_prev_q  <= 1'b0;
        end else begin
            ls_prev_q     <= line_state_filtered;
            id_prev_q     <= id_filtered;
            bvalid_prev_q <= bvalid_s;
            rxdet_prev_q  <= rxdet_s;
        end
    end

    // each event is gated by its own control bit in the wakeup register
    always_comb begin
        events                  = '0;
        events[WK_LINE_STATE]   = ls_prev_q != line_state_filtered;
        events[WK_RX_DETECT]    = rxdet_s && !rxdet_prev_q;
        events[WK_BVALID_LSB]   = bvalid_s && !bvalid_prev_q;
        events[WK_BVALID_LSB+1] = !bvalid_s && bvalid_prev_q;
        events[WK_ID_LSB]       = id_filtered && !id_prev_q;
        events[WK_ID_LSB+1]     = !id_filtered && id_prev_q;
        events                  = events & wake_ctl_q[WK_BITS-1:0];
    end

    assign irq_clr = wr_irq_stat ? hwdata[WK_BITS-1:0] : '0;

    // a new event beats a clear landing in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_q <= RST_WK;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | events;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q[WK_BITS-1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux

    logic [31:0] utmi_word;
    logic [31:0] phy_word;
    logic [31:0] rd_word;

    assign utmi_word = {23'h000000, bvalid_s, hostdisc_s, id_filtered,
                        line_state_filtered, utmi_lo_s};
    assign phy_word  = {phy_s[25:24], 6'h00, phy_s[23:0]};

    always_comb begin
        if (rd_addr_q == OFS_UTMI_STATUS) begin
            rd_word = utmi_word;
        end else if (rd_addr_q == OFS_PHY_STATUS) begin
            rd_word = phy_word;
        end else if (rd_addr_q == OFS_FILTER_CTRL) begin
            rd_word = {16'h0000, filter_q};
        end else if (rd_addr_q == OFS_WAKEUP_CTRL) begin
            rd_word = {26'h0000000, irq_stat_q};
        end else if (rd_addr_q == OFS_IRQ_STATUS) begin
            rd_word = {26'h0000000, irq_stat_q};
        end else if (rd_addr_q == OFS_IRQ_MASK) begin
            rd_word = {16'h0000, irq_mask_q};
        end else begin
            rd_word = 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend_q) begin
            hrdata <= rd_word;
        end
    end

endmodule : upsw_regs

/* File: verif/upsw_chk_sva.sv */
// checker: bus timing, reserved fields, enable writes and debounce stability
`timescale 1ns/100ps
module upsw_chk
    import upsw_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic [1:0]  line_state,
    input wire logic        id_digital,
    input wire logic        receiver_detect_enable,
    input wire logic [1:0]  line_state_filtered,
    input wire logic        id_filtered,
    input wire logic        irq
);
    logic       wr_q;
    logic [7:0] adr_q;
    wire        take  = hsel && hready && htrans[1];
    wire        rd_ap = take && !hwrite;
    wire        wk_dp = wr_q && hready && adr_q == OFS_WAKEUP_CTRL;
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= 1'b0;
        end else if (hready) begin
            wr_q  <= take && hwrite;
            adr_q <= haddr[7:0];
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_wait; rd_ap |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_fast; take && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_phy_rsv; rd_ap && haddr[7:0] == OFS_PHY_STATUS |=> ##1 hrdata[29:24] == 6'h00;
    endproperty
    a_phy_rsv: assert property (p_phy_rsv) else $error("status reserved set");
    property p_wk_rsv; rd_ap && haddr[7:0] == OFS_WAKEUP_CTRL |=> ##1 hrdata[15:6] == 10'h000;
    endproperty
    a_wk_rsv: assert property (p_wk_rsv) else $error("wakeup reserved set");
    property p_rd_stand; $changed(hrdata) |-> $past(!hreadyout); endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
    property p_en_set; wk_dp && hwdata[20] |=> ##1 receiver_detect_enable == $past(hwdata[4], 2);
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable not written");
    property p_en_keep; wk_dp && !hwdata[20] |=> ##1 $stable(receiver_detect_enable); endproperty
    a_en_keep: assert property (p_en_keep) else $error("masked enable moved");
    // a change needs the raw level held well before the synchroniser delay
    property p_ls_filt;
        $changed(line_state_filtered) |->
            $past(line_state, 3) == line_state_filtered &&
            $past(line_state, 5) == line_state_filtered;
    endproperty
    a_ls_filt: assert property (p_ls_filt) else $error("line state glitch passed");
    property p_id_filt;
        $changed(id_filtered) |->
            $past(id_digital, 3) == id_filtered && $past(id_digital, 5) == id_filtered;
    endproperty
    a_id_filt: assert property (p_id_filt) else $error("id glitch passed");
    property p_reset;
        disable iff (1'b0) rst |=> hreadyout && !irq && hrdata == 32'h0 && !receiver_detect_enable;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : upsw_chk

bind upsw_regs upsw_chk chk (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hrdata, .line_state, .id_digital, .receiver_detect_enable,
    .line_state_filtered, .id_filtered, .irq);

/* File: verif/upsw_phy_model.sv */
// partner model: phy and otg sideband levels
`timescale 1ns/100ps
module upsw_phy_model (
    input  wire logic [31:0] phy_cmd,
    input  wire logic [8:0]  utmi_cmd,
    input  wire logic        rxd_cmd,
    output wire logic [31:0] phy_word,
    output wire logic [8:0]  utmi_word,
    output wire logic        rx_det
);
    // levels land mid-cycle, as from an unrelated clock domain
    assign #1.3 phy_word  = phy_cmd;
    assign #1.3 utmi_word = utmi_cmd;
    assign #1.3 rx_det    = rxd_cmd;
endmodule : upsw_phy_model

/* File: verif/testbench.sv */
// testbench: register map, status mirrors, debounce timing and wakeup interrupts
`timescale 1ns/100ps
module testbench;
    import upsw_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [15:0] e;} upsw_row_s;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rxd_cmd = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, phy_cmd = 32'h0;
    logic [8:0]  utmi_cmd = 9'h000;
    logic [31:0] phy_w, hrdata, rd;
    logic [8:0]  utmi_w;
    logic        rxd_w, hreadyout, hresp, irq, rx_en, id_f;
    logic [1:0]  ls_f;
    int          n_errors = 0, compares = 0, cyc = 0;
    // short debounce counts so each interval fits in a few cycles
    localparam int LS0 = 4, LS1 = 8, LS2 = 12, LS3 = 16, ID0 = 5, ID1 = 10, ID2 = 15;
    int          lim_ls [4] = '{LS0, LS1, LS2, LS3};
    int          lim_id [4] = '{ID0, ID1, ID2, ID2};
    logic [31:0] pat [2] = '{32'hA5C3_5A96, 32'h5A3C_A569};
    logic [8:0]  uv [2] = '{9'h1AD, 9'h052};
    logic [9:0]  ev [6] = '{10'h252, 10'h352, 10'h252, 10'h212, 10'h252, 10'h262};
    logic [5:0]  evx [6] = '{6'h02, 6'h06, 6'h0E, 6'h2E, 6'h3E, 6'h3F};
    logic [7:0]  ctl [4] = '{8'h38, 8'h40, 8'h44, 8'h48};
    upsw_row_s   rows [6] = '{'{8'h38, 32'h0000_000F, 16'h0000}, '{8'h38, 32'h000C_0009, 16'h0008},
        '{8'h38, 32'h0003_0006, 16'h000A}, '{8'h48, 32'h003F_002A, 16'h002A},
        '{8'h48, 32'h0001_0015, 16'h002B}, '{8'h70, 32'hFFFF_FFFF, 16'h0000}};
    always #2.5 clk = ~clk;
    upsw_phy_model phy (.phy_cmd(phy_cmd), .utmi_cmd(utmi_cmd), .rxd_cmd(rxd_cmd),
        .phy_word(phy_w), .utmi_word(utmi_w), .rx_det(rxd_w));
    upsw_regs #(.LS_CNT0(LS0), .LS_CNT1(LS1), .LS_CNT2(LS2), .LS_CNT3(LS3),
        .ID_CNT0(ID0), .ID_CNT1(ID1), .ID_CNT2(ID2)) dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .transmit_pll_locked(phy_w[31]),
        .pipe_reset_level(phy_w[30]), .phy_observe_bus(phy_w[23:16]),
        .elastic_buffer_mode_mirror(phy_w[15]), .pipe_power_down(phy_w[14:13]),
        .rx_eq_training(phy_w[12]), .rx_polarity(phy_w[11]), .rx_termination(phy_w[10]),
        .tx_detect_rx_loopback(phy_w[9]), .tx_compliance(phy_w[8]), .tx_ones_zeros(phy_w[7]),
        .phy_status_done(phy_w[6]), .rx_elec_idle(phy_w[5]), .rx_status(phy_w[4:2]),
        .rx_valid(phy_w[1]), .power_present(phy_w[0]), .receiver_detected(rxd_w),
        .b_session_valid(utmi_w[8]), .host_disconnect(utmi_w[7]), .id_digital(utmi_w[6]),
        .line_state(utmi_w[5:4]), .session_end(utmi_w[3]), .vbus_valid(utmi_w[2]),
        .vm_in(utmi_w[1]), .vp_in(utmi_w[0]), .receiver_detect_enable(rx_en),
        .line_state_filtered(ls_f), .id_filtered(id_f), .irq(irq));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsize  <= 3'h2;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // flips raw inputs, expects the old level at the limit and the new one shortly after
    task automatic filt(input logic [8:0] flip, input int lim);
        logic [2:0] was;
        was = utmi_cmd[6:4];
        utmi_cmd <= utmi_cmd ^ flip;
        repeat (lim) @(posedge clk);
        chk({29'h0, id_f, ls_f}, {29'h0, was});
        repeat (6) @(posedge clk);
        chk({29'h0, id_f, ls_f}, {29'h0, was ^ flip[6:4]});
    endtask : filt
    task automatic results();
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 32'h0);
            chk(rd & 32'h0000_FFFF, {16'h0, rows[i].e});
        end
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({29'h0, hresp, irq, rx_en}, 32'h0);
        foreach (ctl[i]) begin
            bus(1'b0, ctl[i], 32'h0);
            chk(rd, 32'h0);
        end
        foreach (pat[i]) begin
            phy_cmd <= pat[i];
            bus(1'b1, OFS_PHY_STATUS, 32'hFFFF_FFFF);
            bus(1'b0, OFS_PHY_STATUS, 32'h0);
            chk(rd, pat[i] & 32'hC0FF_FFFF);
        end
        foreach (uv[i]) begin
            utmi_cmd <= uv[i];
            repeat (30) @(posedge clk);
            bus(1'b0, OFS_UTMI_STATUS, 32'h0);
            chk(rd & 32'h0000_01FF, {23'h0, uv[i]});
        end
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, OFS_FILTER_CTRL, 32'h000F_0000 | 32'(c * 5));
            filt(9'h030, lim_ls[c]);
            filt(9'h040, lim_id[c]);
        end
        bus(1'b1, OFS_FILTER_CTRL, 32'h000F_0000);
        bus(1'b1, OFS_IRQ_MASK, 32'h003F_0000);
        bus(1'b1, OFS_WAKEUP_CTRL, 32'h003F_003F);
        repeat (2) @(posedge clk);
        chk({31'h0, rx_en}, 32'h1);
        foreach (ev[i]) begin
            {rxd_cmd, utmi_cmd} <= ev[i];
            repeat (25) @(posedge clk);
            bus(1'b0, OFS_WAKEUP_CTRL, 32'h0);
            chk(rd & 32'h0000_FFFF, {26'h0, evx[i]});
            chk({31'h0, irq}, 32'h0);
        end
        bus(1'b1, OFS_IRQ_MASK, 32'h0001_0001);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0000_003E);
        bus(1'b1, OFS_IRQ_STATUS, 32'h0000_003E);
        bus(1'b1, OFS_WAKEUP_CTRL, 32'h0002_0000);
        rxd_cmd <= 1'b0;
        repeat (5) @(posedge clk);
        rxd_cmd <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, rx_en}, 32'h1);
        results();
    end
endmodule : testbench
